// file: host_port_pkg.sv
package host_port_pkg;

  localparam int DATA_W = 16;

  // access type select encodings on the two select lines
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_AUTO = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA_FIXED = 2'h3;

  // half-word identifier levels
  localparam logic HW_FIRST = 1'b0;
  localparam logic HW_SECOND = 1'b1;

  // read/write select levels
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // clock and the stall on address writes and second-half fixed-address data writes
  localparam int CLK_HZ = 20_000_000;
  localparam int ADDR_STALL_NS = 100;
  localparam int ADDR_STALL_CYC = (ADDR_STALL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic [1:0] access_type_select;
    logic host_read_write_select;
    logic half_word_identifier;
  } host_qual_t;

  typedef struct packed {
    logic write_fifo_full;
    logic read_fifo_has_data;
    logic addr_update_busy;
  } core_status_t;

endpackage : host_port_pkg

// file: host_pin_sync.sv
`timescale 1ns/10ps
module host_pin_sync
  import host_port_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage only feeds the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : host_pin_sync

// file: host_port_ready_handshake.sv
`timescale 1ns/10ps
module host_port_ready_handshake
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // host pins
  input wire logic HOST_CHIP_SELECT_N,
  input wire logic HOST_DATA_STROBE_A,
  input wire logic HOST_DATA_STROBE_B,
  input wire host_qual_t HOST_QUAL,
  input wire logic [DATA_W-1:0] HOST_DATA_BUS_IN,
  output logic [DATA_W-1:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE,
  output logic HOST_READY_N,
  // core side status and read data
  input wire core_status_t CORE_STATUS,
  input wire logic [DATA_W-1:0] CORE_READ_DATA,
  // core side access events
  output logic ACCESS_START,
  output logic ACCESS_END,
  output host_qual_t ACCESS_QUAL,
  output logic [DATA_W-1:0] ACCESS_WRITE_DATA
);

  typedef enum logic [1:0] {IDLE, READ_WAIT, READ_DRIVE, WRITE_HOLD} phase_t;

  localparam int SYNC_W = 3 + $bits(host_qual_t) + DATA_W;
  localparam int STALL_W = $clog2(ADDR_STALL_CYC + 1);
  localparam logic [STALL_W-1:0] STALL_LOAD = STALL_W'(ADDR_STALL_CYC);

  // a zero stall would let an address write end before the core has taken it
  if (ADDR_STALL_CYC < 1 || DATA_W < 1) begin : g_bad_config
    $error("stall time and data width must both be at least one");
  end

  // select-line decode, shared by the read and write paths
  function automatic logic type_is_data(input logic [1:0] sel);
    return (sel == SEL_DATA_AUTO) || (sel == SEL_DATA_FIXED);
  endfunction : type_is_data

  function automatic logic type_is_auto(input logic [1:0] sel);
    return sel == SEL_DATA_AUTO;
  endfunction : type_is_auto

  logic [SYNC_W-1:0] pins_sync;
  logic cs_n_s;
  logic ds_a_s;
  logic ds_b_s;
  host_qual_t qual_s;
  logic [DATA_W-1:0] wdata_s;
  logic strobe_active;
  logic strobe_prev;
  logic strobe_fall;
  logic strobe_rise;
  logic is_write;
  logic is_data;
  logic is_auto;
  logic read_must_wait;
  logic write_may_stall;
  logic stall_hold;
  logic load_timer;
  logic next_ready_n;
  logic next_drive;
  logic [STALL_W-1:0] stall_count;
  logic [STALL_W-1:0] next_stall_count;
  phase_t phase;
  phase_t next_phase;
  host_qual_t latched_qual;

  // two flops on every pin: the host strobes are asynchronous to CLK
  // the price is three cycles from a pin change to the answer
  host_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .async_in({HOST_CHIP_SELECT_N, HOST_DATA_STROBE_A, HOST_DATA_STROBE_B, HOST_QUAL,
               HOST_DATA_BUS_IN}),
    .sync_out(pins_sync)
  );

  assign {cs_n_s, ds_a_s, ds_b_s, qual_s, wdata_s} = pins_sync;

  // combined strobe from select and the data strobes
  assign strobe_active = !cs_n_s && (ds_a_s ^ ds_b_s);
  assign strobe_fall = strobe_active && !strobe_prev;
  assign strobe_rise = !strobe_active && strobe_prev;

  // qualifiers are caught at strobe start and held through the access
  assign is_write = latched_qual.host_read_write_select == RW_WRITE;
  assign is_data = type_is_data(latched_qual.access_type_select);
  assign is_auto = type_is_auto(latched_qual.access_type_select);
  // fixed-address and address writes run the timer, auto data waits on fifo space
  assign load_timer = !is_data || !is_auto;

  // read stalls only for a first-half auto data read with nothing buffered
  assign read_must_wait = type_is_auto(qual_s.access_type_select)
                          && (qual_s.half_word_identifier == HW_FIRST)
                          && !CORE_STATUS.read_fifo_has_data;

  // write-side stall causes, checked after the strobe ends
  assign write_may_stall =
      (is_data && CORE_STATUS.write_fifo_full)
      || (latched_qual.access_type_select == SEL_ADDRESS)
      || (latched_qual.access_type_select == SEL_DATA_FIXED
          && latched_qual.half_word_identifier == HW_SECOND);

  // auto fifo-full stall ends as soon as space frees; address and fixed-address stalls use the timer
  // the core busy flag can stretch any write stall, it never shortens one
  assign stall_hold = (is_data && is_auto && CORE_STATUS.write_fifo_full)
                      || (!is_auto && is_data && CORE_STATUS.write_fifo_full)
                      || (stall_count != '0)
                      || CORE_STATUS.addr_update_busy;

  // phase machine: a read answers once, a write may park in the hold phase
  always_comb begin
    next_phase = phase;
    next_stall_count = (stall_count != '0) ? stall_count - STALL_W'(1) : stall_count;
    unique case (phase)
      IDLE: begin
        // writes need nothing at strobe start; they are judged at strobe end
        if (strobe_fall && qual_s.host_read_write_select == RW_READ) begin
          next_phase = read_must_wait ? READ_WAIT : READ_DRIVE;
        end
      end
      READ_WAIT: begin
        if (CORE_STATUS.read_fifo_has_data) begin
          next_phase = READ_DRIVE;
        end else if (!strobe_active) begin
          next_phase = IDLE;
        end
      end
      READ_DRIVE: begin
        if (!strobe_active) begin
          next_phase = IDLE;
        end
      end
      WRITE_HOLD: begin
        if (!stall_hold) begin
          next_phase = IDLE;
        end
      end
    endcase
    // a write is completed on strobe rise; stall only for the listed cases
    if (strobe_rise && is_write) begin
      if (write_may_stall) begin
        next_phase = WRITE_HOLD;
        if (load_timer) begin
          next_stall_count = STALL_LOAD;
        end
      end else begin
        next_phase = IDLE;
      end
    end
  end

  // edge history and the qualifier latch
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strobe_prev <= 1'b0;
      phase <= IDLE;
      stall_count <= '0;
      latched_qual <= '0;
    end else begin
      strobe_prev <= strobe_active;
      phase <= next_phase;
      stall_count <= next_stall_count;
      if (strobe_fall) begin
        latched_qual <= qual_s;
      end
    end
  end

  // deselect always shows ready, even mid-stall
  assign next_ready_n = cs_n_s ? 1'b0
                        : (next_phase == READ_WAIT || next_phase == WRITE_HOLD);
  assign next_drive = (next_phase == READ_DRIVE) && !cs_n_s;

  // ready, data drive and core events, all registered
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOST_READY_N <= 1'b0;
      HOST_DATA_BUS_OUT <= '0;
      HOST_DATA_BUS_OE <= 1'b0;
      ACCESS_START <= 1'b0;
      ACCESS_END <= 1'b0;
      ACCESS_QUAL <= '0;
      ACCESS_WRITE_DATA <= '0;
    end else begin
      HOST_READY_N <= next_ready_n;
      HOST_DATA_BUS_OE <= next_drive;
      if (next_phase == READ_DRIVE) begin
        HOST_DATA_BUS_OUT <= CORE_READ_DATA;
      end
      ACCESS_START <= strobe_fall;
      ACCESS_END <= strobe_rise;
      if (strobe_fall) begin
        ACCESS_QUAL <= qual_s;
      end
      // write data sampled while strobe is still active, before host releases it
      if (strobe_active) begin
        ACCESS_WRITE_DATA <= wdata_s;
      end
    end
  end

endmodule : host_port_ready_handshake

// file: host_port_assertions.sv
`timescale 1ns/10ps
module host_port_checker
  import host_port_pkg::*;
(
  // pins and core side
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HOST_CHIP_SELECT_N,
  input wire logic HOST_DATA_STROBE_A,
  input wire logic HOST_DATA_STROBE_B,
  input wire logic HOST_READY_N,
  input wire logic HOST_DATA_BUS_OE,
  input wire core_status_t CORE_STATUS,
  input wire logic ACCESS_START,
  input wire logic ACCESS_END,
  input wire host_qual_t ACCESS_QUAL
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  wire stb = !HOST_CHIP_SELECT_N && (HOST_DATA_STROBE_A ^ HOST_DATA_STROBE_B);
  wire [1:0] ty = ACCESS_QUAL.access_type_select;
  wire hw = ACCESS_QUAL.half_word_identifier;
  wire we = ACCESS_END && !ACCESS_QUAL.host_read_write_select;
  wire rs = ACCESS_START && ACCESS_QUAL.host_read_write_select;
  wire full = CORE_STATUS.write_fifo_full;
  wire ok = HOST_DATA_BUS_OE && !HOST_READY_N;
  chk_strobe_form: assert property (ACCESS_START |-> $past(stb, 3))
    else $error("start without strobe");
  chk_select_ready: assert property (HOST_CHIP_SELECT_N [*4] |=> !HOST_READY_N)
    else $error("ready high while deselected");
  chk_full_stall: assert property (we && ty == SEL_DATA_AUTO && full |-> HOST_READY_N)
    else $error("no stall on full fifo");
  chk_addr_stall: assert property (we && ty == SEL_ADDRESS |-> HOST_READY_N)
    else $error("no stall on address write");
  chk_fixed_half: assert property (
    we && ty == SEL_DATA_FIXED |-> HOST_READY_N == (hw || full))
    else $error("wrong half stalled");
  chk_write_ready: assert property (we && !ty[1] && !full |-> !HOST_READY_N [*3])
    else $error("plain write stalled");
  chk_reg_read: assert property (rs && (!ty[0] || hw) |-> ok)
    else $error("read waited");
  chk_auto_first: assert property (
    rs && ty == SEL_DATA_AUTO && !hw |-> ok == CORE_STATUS.read_fifo_has_data)
    else $error("first auto read wrong");
  cover property (we && ty == SEL_ADDRESS);
  cover property (we && full);
  cover property (rs && !CORE_STATUS.read_fifo_has_data);
endmodule : host_port_checker

bind host_port_ready_handshake host_port_checker host_port_checker_inst (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .HOST_CHIP_SELECT_N(HOST_CHIP_SELECT_N),
  .HOST_DATA_STROBE_A(HOST_DATA_STROBE_A),
  .HOST_DATA_STROBE_B(HOST_DATA_STROBE_B),
  .HOST_READY_N(HOST_READY_N),
  .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
  .CORE_STATUS(CORE_STATUS),
  .ACCESS_START(ACCESS_START),
  .ACCESS_END(ACCESS_END),
  .ACCESS_QUAL(ACCESS_QUAL)
);

// file: host_model.sv
`timescale 1ns/10ps
module host_model
  import host_port_pkg::*;
(
  input wire logic CLK,
  input wire logic HOST_READY_N,
  input wire logic HOST_DATA_BUS_OE,
  input wire logic [DATA_W-1:0] HOST_DATA_BUS_OUT,
  output logic HOST_CHIP_SELECT_N,
  output logic HOST_DATA_STROBE_A,
  output logic HOST_DATA_STROBE_B,
  output host_qual_t HOST_QUAL,
  output logic [DATA_W-1:0] HOST_DATA_BUS_IN
);
  // no address strobe pin here: held high by the host
  initial begin
    HOST_CHIP_SELECT_N = 1'b1;
    HOST_DATA_STROBE_A = 1'b0;
    HOST_DATA_STROBE_B = 1'b0;
    HOST_QUAL = 4'h0;
    HOST_DATA_BUS_IN = 16'h0000;
  end
  task automatic acc(input host_qual_t q, input logic [15:0] d, output int st,
    output logic [15:0] rd);
    int n;
    st = 0;
    n = 0;
    @(negedge CLK);
    HOST_CHIP_SELECT_N = 1'b0;
    HOST_QUAL = q; // set ahead, held over the strobe
    HOST_DATA_BUS_IN = d;
    @(negedge CLK);
    HOST_DATA_STROBE_A = ~HOST_DATA_STROBE_B;
    // strobe ends only with ready low, or after the 30-cycle timeout
    // st counts only cycles with ready high; the pipeline latency is not a stall
    while (((q.host_read_write_select && !HOST_DATA_BUS_OE) || HOST_READY_N) && n < 30) begin
      @(negedge CLK);
      st += int'(HOST_READY_N);
      n++;
    end
    if (n >= 30) st = 30;
    rd = HOST_DATA_BUS_OUT;
    repeat (6) @(negedge CLK);
    HOST_DATA_STROBE_A = HOST_DATA_STROBE_B;
    HOST_DATA_BUS_IN = ~d; // stale data would hide a late sample
    repeat (24) @(negedge CLK) st += int'(!q.host_read_write_select && HOST_READY_N);
  endtask : acc
endmodule : host_model

// file: testbench.sv
`timescale 1ns/10ps
module testbench
  import host_port_pkg::*;
;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  core_status_t CORE_STATUS = 3'h2;
  logic [DATA_W-1:0] CORE_READ_DATA = 16'h0000;
  wire HOST_CHIP_SELECT_N, HOST_DATA_STROBE_A, HOST_DATA_STROBE_B, HOST_DATA_BUS_OE;
  wire HOST_READY_N, ACCESS_START, ACCESS_END;
  host_qual_t HOST_QUAL, ACCESS_QUAL;
  logic [DATA_W-1:0] HOST_DATA_BUS_IN, HOST_DATA_BUS_OUT, ACCESS_WRITE_DATA, rd;
  int fails = 0;
  int tests_run = 0;
  int st;
  always #25 CLK = ~CLK;
  host_port_ready_handshake host_port_ready_handshake_inst (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .HOST_CHIP_SELECT_N(HOST_CHIP_SELECT_N),
    .HOST_DATA_STROBE_A(HOST_DATA_STROBE_A),
    .HOST_DATA_STROBE_B(HOST_DATA_STROBE_B),
    .HOST_QUAL(HOST_QUAL),
    .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
    .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT),
    .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
    .HOST_READY_N(HOST_READY_N),
    .CORE_STATUS(CORE_STATUS),
    .CORE_READ_DATA(CORE_READ_DATA),
    .ACCESS_START(ACCESS_START),
    .ACCESS_END(ACCESS_END),
    .ACCESS_QUAL(ACCESS_QUAL),
    .ACCESS_WRITE_DATA(ACCESS_WRITE_DATA)
  );
  host_model host_model_inst (
    .CLK(CLK),
    .HOST_READY_N(HOST_READY_N),
    .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE),
    .HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT),
    .HOST_CHIP_SELECT_N(HOST_CHIP_SELECT_N),
    .HOST_DATA_STROBE_A(HOST_DATA_STROBE_A),
    .HOST_DATA_STROBE_B(HOST_DATA_STROBE_B),
    .HOST_QUAL(HOST_QUAL),
    .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN)
  );
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input host_qual_t q, input logic [15:0] d);
    host_model_inst.acc(q, d, st, rd);
    if (st >= 30) begin
      fails++;
      wrap_up();
    end
  endtask : run
  task automatic t_reads;
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      CORE_READ_DATA = 16'h3C00 | 16'(i);
      run({2'(i >> 1), RW_READ, 1'(i)}, 16'h0000);
      check(16'(st), 16'h0000);
      check(rd, 16'h3C00 | 16'(i));
      check(16'(ACCESS_QUAL), 16'({2'(i >> 1), RW_READ, 1'(i)}));
    end
    $display("reads done");
  endtask : t_reads
  task automatic t_stall;
    CORE_STATUS = 3'h0;
    CORE_READ_DATA = 16'h9E17;
    fork
      run({SEL_DATA_AUTO, RW_READ, HW_FIRST}, 16'h0000);
      begin
        repeat (12) @(negedge CLK);
        CORE_STATUS = 3'h2;
      end
    join
    check(16'(st > 0), 16'h0001);
    check(rd, 16'h9E17);
    $display("read stall done");
  endtask : t_stall
  task automatic t_writes;
    for (int i = 0; i < 8; i++) begin
      // full on the second auto half, core busy on the first address half
      CORE_STATUS = {i == 3, 1'b1, i == 4};
      fork
        run({2'(i >> 1), RW_WRITE, 1'(i)}, 16'h5A00 | 16'(i));
        begin
          repeat (19) @(negedge CLK);
          check(16'(HOST_READY_N), 16'(i inside {3, 4}));
          CORE_STATUS = 3'h2;
        end
      join
      check(ACCESS_WRITE_DATA, 16'h5A00 | 16'(i));
      check(16'(st > 0), 16'(i inside {3, 4, 5, 7}));
      check(16'(HOST_READY_N), 16'h0000);
    end
    $display("writes done");
  endtask : t_writes
  task automatic t_select;
    CORE_STATUS = 3'h0;
    fork
      run({SEL_DATA_AUTO, RW_READ, HW_FIRST}, 16'h0000);
      begin
        repeat (10) @(negedge CLK);
        host_model_inst.HOST_CHIP_SELECT_N = 1'b1;
        repeat (6) @(negedge CLK);
        check(16'(HOST_READY_N), 16'h0000);
        // reselect with data buffered; the waiting read went back to idle, so the strobe restarts as a new read that completes
        host_model_inst.HOST_CHIP_SELECT_N = 1'b0;
        CORE_STATUS = 3'h2;
      end
    join
    check(rd, 16'h9E17);
    $display("deselect done");
  endtask : t_select
  initial begin
    repeat (2) @(negedge CLK);
    RESET_N = 1'b1;
    t_reads();
    t_stall();
    t_writes();
    t_select();
    wrap_up();
  end
endmodule : testbench
